//--- hdl/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

  // ********************************************************************
  // Register map (word indices, byte address divided by four, on a 32-bit Avalon-MM bus).
  // ********************************************************************
  localparam int ADDR_W = 10;
  localparam logic [7:0] IDX_RESULT_HI  = 8'he6;
  localparam logic [7:0] IDX_RESULT_LO  = 8'he7;
  localparam logic [7:0] IDX_CTRL_STAT  = 8'he8;
  localparam logic [7:0] IDX_TRIG_CTRL  = 8'he9;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hea;
  localparam logic [7:0] IDX_IRQ_MASK   = 8'heb;
  localparam logic [7:0] IDX_CHAN_DATA  = 8'hee;

  // ********************************************************************
  // Field positions and reset values.
  // ********************************************************************
  localparam int BIT_END_FLAG   = 7;
  localparam int BIT_IRQ_ENABLE = 6;
  localparam int BIT_START      = 5;
  localparam int BIT_SCAN       = 4;
  localparam int BIT_SPEED      = 3;
  localparam int BIT_TRIG_EN    = 7;
  localparam logic [7:0] CTRL_STAT_RESET = 8'h00;
  localparam logic [7:0] TRIG_CTRL_RESET = 8'h7f;
  localparam logic [7:0] TRIG_CTRL_ONES  = 8'h7f;
  localparam int RESULT_W = 10;

  // Event bits of the interrupt status register.
  localparam int EV_END     = 0;
  localparam int EV_TRIGGER = 1;
  localparam int EV_W       = 2;

  // ********************************************************************
  // Timing: states per conversion, one state per system clock.
  // ********************************************************************
  localparam int CLOCK_MHZ        = 100;
  localparam int STATES_SLOW      = 266;
  localparam int STATES_FAST      = 134;
  localparam logic [8:0] CYC_SLOW = 9'(STATES_SLOW);
  localparam logic [8:0] CYC_FAST = 9'(STATES_FAST);

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_CONVERT = 2'b01,
    ST_NEXT    = 2'b10
  } conv_state_t;

  typedef struct packed {
    logic       end_irq_enable;
    logic       scan;
    logic       speed;
    logic [2:0] chan;
  } conv_cfg_t;

  typedef struct packed {
    logic [2:0]          chan;
    logic [RESULT_W-1:0] data;
  } conv_sample_t;

endpackage : adc_ctrl_pkg

//--- hdl/adc_conversion_control.sv
`timescale 1ns/1ps
// Summary of operation
// - With the external trigger enable at 0 the trigger pin is ignored and only software starts.
// - With the external trigger enable at 1 a falling edge on the trigger pin starts a conversion.
// - Speed select 0 takes 266 states per conversion and speed select 1 takes 134 states.
// - Single mode converts the channel in the select field; scan mode cycles a group from its first.
// - While the start bit is 0 no conversion runs.
// - Single mode converts once and then clears the start bit by itself.
// - Scan mode converts the selected channels in rotation without pause while start stays 1.
// - Scan ends only on a software clear, reset or standby, and each of these clears start.
// - The interrupt enable bit suppresses or forwards the conversion-end request on conv_end_irq; on irq the end event also passes when its mask bit is 1.
// - Single mode sets the end flag when the selected channel completes.
// - Scan mode sets the end flag only after every channel of the group is converted.
// - The end flag clears only on a write of 0 after a read that saw it at 1.
// - Writing 1 to the end flag leaves it unchanged.
// - The result of channel D reads as a high byte and a low byte at two addresses.
module adc_conversion_control
  import adc_ctrl_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                arst_n,
  input  wire logic                clk_en,
  input  wire logic                standby,
  input  wire logic [ADDR_W-1:0]   avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic      [31:0]         avs_readdata,
  output logic                     avs_waitrequest,
  output logic      [1:0]          avs_response,
  input  wire logic                ext_conv_trigger_n,
  input  wire logic                sample_valid,
  input  wire logic [RESULT_W-1:0] sample_data,
  output logic      [2:0]          conv_channel,
  output logic                     conv_active,
  output logic                     conv_end_irq,
  output logic                     irq
);

  // ********************************************************************
  // Bus slave: one wait cycle, then the access completes.
  // ********************************************************************
  logic       ack_q;
  logic       access;
  logic       wr_stb;
  logic       rd_stb;
  logic [7:0] index;
  logic       lane0;

  assign access          = (avs_read | avs_write) & clk_en;
  assign avs_waitrequest = ~ack_q;
  assign wr_stb          = avs_write & ack_q & clk_en;
  assign rd_stb          = avs_read & ack_q & clk_en;
  assign index           = avs_address[9:2];
  assign lane0           = avs_byteenable[0];

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ack_q <= 1'b0;
    end else if (clk_en) begin
      ack_q <= access & ~ack_q;
    end
  end

  // ********************************************************************
  // Trigger pin synchroniser and falling-edge detect.
  // ********************************************************************
  logic trig_meta_q;
  logic trig_sync_q;
  logic trig_prev_q;
  logic trig_fall;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      trig_meta_q <= 1'b1;
      trig_sync_q <= 1'b1;
      trig_prev_q <= 1'b1;
    end else if (clk_en) begin
      trig_meta_q <= ext_conv_trigger_n;
      trig_sync_q <= trig_meta_q;
      trig_prev_q <= trig_sync_q;
    end
  end

  assign trig_fall = trig_prev_q & ~trig_sync_q;

  // ********************************************************************
  // Control registers.
  // ********************************************************************
  conv_cfg_t           cfg_q;
  logic                start_q;
  logic                end_flag_q;
  logic                flag_seen_q;
  logic                ext_trigger_enable;
  logic                trig_en_q;
  logic [EV_W-1:0]     ev_status_q;
  logic [EV_W-1:0]     ev_mask_q;
  conv_state_t         state_q;
  logic [8:0]          cnt_q;
  logic [2:0]          chan_q;
  logic [RESULT_W-1:0] result_q [8];
  logic                conv_done;
  logic                last_chan;
  logic                sw_start;
  logic                hw_start;
  logic                sw_stop;
  logic                set_end;
  logic [2:0]          first_chan;
  logic [2:0]          final_chan;

  assign ext_trigger_enable = trig_en_q;
  assign sw_start   = wr_stb && index == IDX_CTRL_STAT && lane0 && avs_writedata[BIT_START];
  assign hw_start   = ext_trigger_enable & trig_fall;
  assign sw_stop    = wr_stb && index == IDX_CTRL_STAT && lane0 && !avs_writedata[BIT_START];
  assign first_chan = cfg_q.scan ? {cfg_q.chan[2], 2'b00} : cfg_q.chan;
  assign final_chan = cfg_q.chan;
  assign last_chan  = chan_q == final_chan;
  assign conv_done  = state_q == ST_CONVERT && cnt_q == 9'h001;
  assign set_end    = conv_done && (!cfg_q.scan || last_chan);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q     <= '0;
      trig_en_q <= 1'b0;
    end else if (clk_en) begin
      if (wr_stb && lane0 && index == IDX_CTRL_STAT) begin
        cfg_q.end_irq_enable <= avs_writedata[BIT_IRQ_ENABLE];
        cfg_q.scan           <= avs_writedata[BIT_SCAN];
        cfg_q.speed          <= avs_writedata[BIT_SPEED];
        cfg_q.chan           <= avs_writedata[2:0];
      end
      if (wr_stb && lane0 && index == IDX_TRIG_CTRL) begin
        trig_en_q <= avs_writedata[BIT_TRIG_EN];
      end
    end
  end

  // Start bit: set by software or trigger; cleared by end of single, write 0 or standby.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      start_q <= 1'b0;
    end else if (clk_en) begin
      if (standby) begin
        start_q <= 1'b0;
      end else if (sw_start || hw_start) begin
        start_q <= 1'b1;
      end else if (sw_stop) begin
        start_q <= 1'b0;
      end else if (conv_done && !cfg_q.scan) begin
        start_q <= 1'b0;
      end
    end
  end

  // End flag: hardware set wins over a read-then-write-0 clear.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      end_flag_q  <= 1'b0;
      flag_seen_q <= 1'b0;
    end else if (clk_en) begin
      // Read data are latched on the edge that takes the request, so the flag value
      // that software sees is the one present at that edge, not one cycle later.
      if (access && !ack_q && avs_read && index == IDX_CTRL_STAT && end_flag_q) begin
        flag_seen_q <= 1'b1;
      end else if (wr_stb && lane0 && index == IDX_CTRL_STAT) begin
        flag_seen_q <= 1'b0;
      end
      if (set_end) begin
        end_flag_q <= 1'b1;
      end else if (wr_stb && lane0 && index == IDX_CTRL_STAT && flag_seen_q
                   && !avs_writedata[BIT_END_FLAG]) begin
        end_flag_q <= 1'b0;
      end
    end
  end

  // ********************************************************************
  // Conversion sequencer.
  // ********************************************************************
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      cnt_q   <= '0;
      chan_q  <= '0;
    end else if (clk_en) begin
      case (state_q)
        ST_IDLE: begin
          if (start_q && !standby) begin
            state_q <= ST_CONVERT;
            chan_q  <= first_chan;
            cnt_q   <= cfg_q.speed ? CYC_FAST : CYC_SLOW;
          end
        end
        ST_CONVERT: begin
          if (!start_q || standby) begin
            state_q <= ST_IDLE;
          end else if (conv_done) begin
            state_q <= cfg_q.scan ? ST_NEXT : ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 9'h001;
          end
        end
        ST_NEXT: begin
          if (!start_q || standby) begin
            state_q <= ST_IDLE;
          end else begin
            state_q <= ST_CONVERT;
            chan_q  <= last_chan ? first_chan : chan_q + 3'h1;
            cnt_q   <= (cfg_q.speed ? CYC_FAST : CYC_SLOW) - 9'h001;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Results are captured per channel; sample_data is taken at the last state.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 8; i++) begin
        result_q[i] <= '0;
      end
    end else if (clk_en && conv_done) begin
      result_q[chan_q] <= sample_valid ? sample_data : result_q[chan_q];
    end
  end

  // ********************************************************************
  // Interrupt status and mask.
  // ********************************************************************
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;

  assign ev_set = {hw_start, set_end};
  assign ev_clr = (wr_stb && lane0 && index == IDX_IRQ_STATUS) ? avs_writedata[EV_W-1:0] : '0;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ev_status_q <= '0;
      ev_mask_q   <= '0;
    end else if (clk_en) begin
      ev_status_q <= (ev_status_q & ~ev_clr) | ev_set;
      if (wr_stb && lane0 && index == IDX_IRQ_MASK) begin
        ev_mask_q <= avs_writedata[EV_W-1:0];
      end
    end
  end

  assign conv_end_irq = end_flag_q & cfg_q.end_irq_enable;
  assign irq          = |(ev_status_q & ev_mask_q) | conv_end_irq;
  assign conv_channel = chan_q;
  assign conv_active  = state_q == ST_CONVERT;

  // ********************************************************************
  // Read data mux; result is left-justified in 16 bits.
  // ********************************************************************
  logic [15:0] result_d16;
  logic [31:0] rdata_d;

  assign result_d16 = {result_q[3], 6'h00};

  always_comb begin
    rdata_d = 32'h0000_0000;
    case (index)
      IDX_RESULT_HI:  rdata_d[7:0] = result_d16[15:8];
      IDX_RESULT_LO:  rdata_d[7:0] = result_d16[7:0];
      IDX_CTRL_STAT:  rdata_d[7:0] = {end_flag_q, cfg_q.end_irq_enable, start_q, cfg_q.scan,
                                      cfg_q.speed, cfg_q.chan};
      IDX_TRIG_CTRL:  rdata_d[7:0] = {trig_en_q, TRIG_CTRL_ONES[6:0]};
      IDX_IRQ_STATUS: rdata_d[EV_W-1:0] = ev_status_q;
      IDX_IRQ_MASK:   rdata_d[EV_W-1:0] = ev_mask_q;
      default:        rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= '0;
      avs_response <= 2'h0;
    end else if (clk_en) begin
      if (access && !ack_q) begin
        avs_readdata <= rdata_d;
        avs_response <= 2'h0;
      end
    end
  end

  // ********************************************************************
  // Assertions.
  // ********************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  a_trig_ignored: assert property (clk_en && !trig_en_q && trig_fall && !sw_start && !start_q
    |=> !start_q) else $error("trigger started while disabled");
  a_trig_starts: assert property (clk_en && trig_en_q && trig_fall && !standby
    |=> start_q) else $error("trigger edge did not start");
  a_fast_length: assert property (clk_en && state_q == ST_IDLE && start_q && !standby
    && cfg_q.speed |=> cnt_q == CYC_FAST) else $error("fast count wrong");
  a_idle_stopped: assert property (!start_q && clk_en |=> state_q != ST_CONVERT || $past(sw_start)
    || $past(hw_start)) else $error("converting while stopped");
  a_single_clear: assert property (clk_en && conv_done && !cfg_q.scan && !standby && !sw_start
    && !hw_start |=> !start_q) else $error("single start not cleared");
  a_scan_keeps: assert property (clk_en && conv_done && cfg_q.scan && start_q && !standby
    && !sw_stop |=> start_q ##1 state_q == ST_CONVERT) else $error("scan stopped");
  a_standby_stop: assert property (clk_en && standby |=> !start_q) else
    $error("standby left start set");
  a_one_no_clear: assert property (clk_en && wr_stb && index == IDX_CTRL_STAT && lane0
    && avs_writedata[BIT_END_FLAG] && end_flag_q |=> end_flag_q) else
    $error("writing one cleared flag");
  a_irq_gate: assert property (conv_end_irq |-> irq && end_flag_q && cfg_q.end_irq_enable) else
    $error("end request gating wrong");
  a_scan_flag: assert property (clk_en && conv_done && cfg_q.scan && !last_chan && !end_flag_q
    |=> !end_flag_q) else $error("scan flag set early");

  c_single_done: cover property (conv_done && !cfg_q.scan);
  c_scan_wrap:   cover property (state_q == ST_NEXT && last_chan);
  c_flag_clear:  cover property (end_flag_q ##1 !end_flag_q);
  c_trig_start:  cover property (hw_start);
  c_standby_hit: cover property (standby && start_q);

  // ********************************************************************
  // Sequencer and result checks.
  // ********************************************************************
  // These watch the first cycle of each conversion started from idle, the end of a single
  // conversion and the capture of the exposed result, so that a broken
  // counter load or channel pick is caught where it happens.

  a_slow_length: assert property (clk_en && state_q == ST_IDLE && start_q && !standby
    && !cfg_q.speed |=> cnt_q == CYC_SLOW) else $error("slow count wrong");

  a_single_chan: assert property (clk_en && state_q == ST_IDLE && start_q && !standby
    && !cfg_q.scan |=> chan_q == $past(cfg_q.chan)) else
    $error("single channel wrong");

  a_scan_first: assert property (clk_en && state_q == ST_IDLE && start_q && !standby
    && cfg_q.scan |=> chan_q == {$past(cfg_q.chan[2]), 2'b00}) else
    $error("scan first channel wrong");

  a_start_low_idle: assert property (clk_en && !start_q && state_q != ST_IDLE
    |=> state_q == ST_IDLE) else $error("sequencer ran without start");

  a_single_flag: assert property (clk_en && conv_done && !cfg_q.scan |=> end_flag_q) else
    $error("single end flag not set");

  a_clear_needs_read: assert property (clk_en && end_flag_q && !flag_seen_q
    |=> end_flag_q) else $error("flag cleared without read");

  a_result_hold: assert property (clk_en && conv_done && chan_q == 3'h3 && sample_valid
    |=> result_q[3] == $past(sample_data)) else $error("result not captured");

endmodule : adc_conversion_control

//--- verification/adc_front_model.sv
`timescale 1ns/1ps
module adc_front_model
  import adc_ctrl_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                fire,
  input  wire logic [2:0]          conv_channel,
  input  wire logic                conv_active,
  output logic                     ext_conv_trigger_n,
  output logic                     sample_valid,
  output logic      [RESULT_W-1:0] sample_data
);
  // ********************************************************************
  // Trigger pin and analog front end.
  // ********************************************************************
  logic [2:0] low_cnt = 3'h0;

  // The trigger pin idles high on its pull-up and is pulled low for four cycles.
  assign ext_conv_trigger_n = (low_cnt == 3'h0);
  assign sample_valid       = conv_active;

  // Outside a conversion the data lines carry the inverted channel and 7'h54 so that no stale value looks valid.
  always @(posedge clock) begin
    if (fire) begin
      low_cnt <= 3'h4;
    end else if (low_cnt != 3'h0) begin
      low_cnt <= low_cnt - 3'h1;
    end
    if (conv_active) begin
      sample_data <= {conv_channel, 7'h2b};
    end else begin
      sample_data <= {~conv_channel, 7'h54};
    end
  end
endmodule : adc_front_model

//--- verification/test_adc_conversion_control.sv
`timescale 1ns/1ps
module test_adc_conversion_control
  import adc_ctrl_pkg::*;
;
  // ********************************************************************
  // Stimulus, bus tasks and scenarios.
  // ********************************************************************
  logic                clock = 1'b0;
  logic                arst_n = 1'b0;
  logic                standby = 1'b0;
  logic [ADDR_W-1:0]   avs_address = '0;
  logic                avs_read = 1'b0;
  logic                avs_write = 1'b0;
  logic [31:0]         avs_writedata = '0;
  logic [31:0]         avs_readdata;
  logic                avs_waitrequest;
  logic                fire = 1'b0;
  logic                ext_conv_trigger_n;
  logic                sample_valid;
  logic [RESULT_W-1:0] sample_data;
  logic [2:0]          conv_channel;
  logic                conv_active;
  logic                conv_end_irq;
  logic                irq;
  logic [7:0]          rd;
  int                  error_cnt = 0;
  int                  cmp_count = 0;
  int                  cycles = 0;
  int                  run = 0;
  int                  last_len = 0;

  adc_conversion_control DUT (.clock(clock), .arst_n(arst_n), .clk_en(1'b1), .standby(standby),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'h1), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(), .ext_conv_trigger_n(ext_conv_trigger_n),
    .sample_valid(sample_valid), .sample_data(sample_data), .conv_channel(conv_channel),
    .conv_active(conv_active), .conv_end_irq(conv_end_irq), .irq(irq));

  adc_front_model front (.clock(clock), .fire(fire), .conv_channel(conv_channel),
    .conv_active(conv_active), .ext_conv_trigger_n(ext_conv_trigger_n),
    .sample_valid(sample_valid), .sample_data(sample_data));

  initial begin
    forever #5 clock = ~clock;
  end

  // Measures how many cycles each conversion keeps the converter busy.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (conv_active) begin
      run <= run + 1;
    end else if (run != 0) begin
      last_len <= run;
      run <= 0;
    end
    if (cycles == 30000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic bus_access(input logic wr, input logic [7:0] idx, input logic [7:0] val);
    avs_address   <= {idx, 2'b00};
    avs_writedata <= {24'h0, val};
    avs_write     <= wr;
    avs_read      <= ~wr;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clock);
    end
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clock);
  endtask : bus_access

  task automatic wait_active(input logic lvl);
    for (int n = 0; n < 400 && conv_active !== lvl; n++) begin
      @(posedge clock);
    end
  endtask : wait_active

  task automatic reset_values();
    bus_access(1'b0, IDX_CTRL_STAT, 8'h00);
    check(rd, CTRL_STAT_RESET, "control reset");
    bus_access(1'b0, IDX_TRIG_CTRL, 8'h00);
    check(rd, TRIG_CTRL_RESET, "trigger reset");
    bus_access(1'b1, 8'h10, 8'hff);
    bus_access(1'b0, 8'h10, 8'h00);
    check(rd, 8'h00, "unmapped read");
  endtask : reset_values

  task automatic single_and_clear();
    logic [9:0] exp;
    exp = {3'd3, 7'h2b};
    bus_access(1'b1, IDX_CTRL_STAT, 8'h6b);
    wait_active(1'b1);
    wait_active(1'b0);
    repeat (3) @(posedge clock);
    check(8'(last_len <= STATES_FAST && last_len > 0), 8'h01, "fast length");
    bus_access(1'b0, IDX_CTRL_STAT, 8'h00);
    check(rd, 8'hcb, "single end");
    check({7'h0, conv_end_irq}, 8'h01, "end request");
    bus_access(1'b0, IDX_RESULT_HI, 8'h00);
    check(rd, exp[9:2], "result high");
    bus_access(1'b0, IDX_RESULT_LO, 8'h00);
    check(rd, {exp[1:0], 6'h00}, "result low");
    bus_access(1'b1, IDX_CTRL_STAT, 8'h8b);
    bus_access(1'b1, IDX_CTRL_STAT, 8'h0b);
    bus_access(1'b0, IDX_CTRL_STAT, 8'h00);
    check(rd, 8'h8b, "flag kept");
    bus_access(1'b1, IDX_CTRL_STAT, 8'h0b);
    bus_access(1'b0, IDX_CTRL_STAT, 8'h00);
    check(rd, 8'h0b, "flag cleared");
    check({7'h0, conv_end_irq}, 8'h00, "request dropped");
  endtask : single_and_clear

  task automatic trigger_and_irq();
    bus_access(1'b1, IDX_CTRL_STAT, 8'h03);
    fire <= 1'b1;
    @(posedge clock);
    fire <= 1'b0;
    repeat (20) @(posedge clock);
    check({7'h0, conv_active}, 8'h00, "trigger ignored");
    bus_access(1'b1, IDX_TRIG_CTRL, 8'h80);
    fire <= 1'b1;
    @(posedge clock);
    fire <= 1'b0;
    wait_active(1'b1);
    check({7'h0, conv_active}, 8'h01, "trigger start");
    wait_active(1'b0);
    repeat (3) @(posedge clock);
    check(8'(last_len <= STATES_SLOW && last_len > STATES_FAST), 8'h01, "slow length");
    check({6'h0, conv_end_irq, irq}, 8'h00, "request disabled");
    bus_access(1'b1, IDX_IRQ_MASK, 8'h01);
    check({7'h0, irq}, 8'h01, "irq unmasked");
    bus_access(1'b1, IDX_IRQ_STATUS, 8'h01);
    check({7'h0, irq}, 8'h00, "irq cleared");
    bus_access(1'b0, IDX_CTRL_STAT, 8'h00);
    bus_access(1'b1, IDX_CTRL_STAT, 8'h00);
  endtask : trigger_and_irq

  task automatic scan_and_stop();
    logic [2:0] seq [3];
    seq = '{3'd4, 3'd5, 3'd4};
    bus_access(1'b1, IDX_CTRL_STAT, 8'h3d);
    for (int k = 0; k < 3; k++) begin
      wait_active(1'b1);
      check({5'h0, conv_channel}, {5'h0, seq[k]}, "scan channel");
      wait_active(1'b0);
      if (k == 0) begin
        bus_access(1'b0, IDX_CTRL_STAT, 8'h00);
        check(rd, 8'h3d, "flag early");
      end
    end
    bus_access(1'b0, IDX_CTRL_STAT, 8'h00);
    check(rd, 8'hbd, "scan flag");
    bus_access(1'b1, IDX_CTRL_STAT, 8'h1d);
    repeat (300) @(posedge clock);
    check({7'h0, conv_active}, 8'h00, "scan stopped");
    bus_access(1'b1, IDX_CTRL_STAT, 8'h3d);
    wait_active(1'b1);
    standby <= 1'b1;
    repeat (3) @(posedge clock);
    standby <= 1'b0;
    bus_access(1'b0, IDX_CTRL_STAT, 8'h00);
    check(rd & 8'h20, 8'h00, "standby start");
    check({7'h0, conv_active}, 8'h00, "standby stop");
    bus_access(1'b1, IDX_CTRL_STAT, 8'h3d);
    wait_active(1'b1);
    arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    bus_access(1'b0, IDX_CTRL_STAT, 8'h00);
    check(rd, 8'h00, "reset start");
    check({7'h0, conv_active}, 8'h00, "reset stop");
  endtask : scan_and_stop

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (10) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    reset_values();
    single_and_clear();
    trigger_and_irq();
    scan_and_stop();
    tally_and_finish();
  end
endmodule : test_adc_conversion_control
